// *** mqc_pkg.sv ***
package mqc_pkg;

  // Data path and storage geometry.
  localparam int DATA_W = 18;
  localparam int NUM_Q = 3;
  localparam int QID_W = 2;
  localparam int MEM_AW = 12;
  localparam int MEM_WORDS = 4096;
  localparam int BLK_SHIFT = 8;
  localparam int QSZ_W = 13;
  localparam int CELL_CNT_W = 10;
  localparam int FIFO_DEPTH = 32;

  // Configuration register widths.
  localparam int REG_AW = 4;
  localparam int REG_DW = 9;
  localparam int PORT_W = 5;
  localparam int LEN1_W = 5;
  localparam int LEN_W = 4;
  localparam int CSZ_W = 6;

  // Configuration register indices on the auxiliary bus.
  localparam logic [REG_AW-1:0] REG_PORT = 4'h0;
  localparam logic [REG_AW-1:0] REG_Q1_LEN = 4'h1;
  localparam logic [REG_AW-1:0] REG_Q2_LEN = 4'h2;
  localparam logic [REG_AW-1:0] REG_Q3_LEN = 4'h3;
  localparam logic [REG_AW-1:0] REG_CELL_SIZE = 4'h4;
  localparam logic [REG_AW-1:0] REG_L1_SET = 4'h5;
  localparam logic [REG_AW-1:0] REG_L1_CLR = 4'h6;
  localparam logic [REG_AW-1:0] REG_L2_SET = 4'h7;
  localparam logic [REG_AW-1:0] REG_L2_CLR = 4'h8;
  localparam logic [REG_AW-1:0] REG_L3_SET = 4'h9;
  localparam logic [REG_AW-1:0] REG_L3_CLR = 4'hA;

  // Reset values.
  localparam logic [PORT_W-1:0] PORT_RST = 5'h00;
  localparam logic [LEN1_W-1:0] Q1_LEN_RST = 5'h08;
  localparam logic [LEN_W-1:0] Q2_LEN_RST = 4'h6;
  localparam logic [LEN_W-1:0] Q3_LEN_RST = 4'h2;
  localparam logic [CSZ_W-1:0] CSZ_RST = 6'h1B;
  localparam logic [REG_DW-1:0] LVL_SET_RST [NUM_Q] =
    '{9'h047, 9'h033, 9'h00D};
  localparam logic [REG_DW-1:0] LVL_CLR_RST [NUM_Q] =
    '{9'h046, 9'h032, 9'h00C};

  // Maps the two read select pins onto a queue index.
  function automatic logic [QID_W-1:0] mqc_sel_queue(
    input logic [1:0] sel
  );
    case (sel)
      2'h2: mqc_sel_queue = 2'h1;
      2'h3: mqc_sel_queue = 2'h2;
      default: mqc_sel_queue = 2'h0;
    endcase
  endfunction

endpackage

// *** mqc_fifo.sv ***
module mqc_fifo #(
  parameter int WIDTH = 20,
  parameter int DEPTH = 32
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // Filling side.
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Draining side.
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];
  logic [AW-1:0] wptr;
  logic [AW-1:0] rptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  assign in_ready = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data = store[rptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      store[wptr] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wptr <= '0;
      rptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wptr <= (wptr == AW'(DEPTH - 1)) ? '0 : wptr + AW'(1);
      end
      if (pop) begin
        rptr <= (rptr == AW'(DEPTH - 1)) ? '0 : rptr + AW'(1);
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

endmodule // mqc_fifo

// *** mqc_core.sv ***
// Notes on behaviour
// - Write clock edge stores word into enabled queue.
// - Read clock edge delivers word from selected queue.
// - Low enables mean no write or read.
// - Write and read clocks run independently, synchronised.
// - Select 00/01 queue one, 10 two, 11 three.
// - Storage splits into up to three queues.
// - Occupancy is counted in whole cells.
// - Eleven configuration registers writable and readable.
// - Port control: five bits, reset zero.
// - Queue one length: five bits, reset eight.
// - Queue two length: four bits, reset six.
// - Queue three length: four bits, reset two.
// - Cell size words: six bits, reset 27.
// - Flag one low at set threshold count.
// - Flag one high at clear threshold count.
// - Flag two hysteresis on queue two cells.
// - Flag three hysteresis on queue three cells.
module mqc_core
  import mqc_pkg::*;
#(
  parameter int BUF_DEPTH = FIFO_DEPTH
) (
  // Clock and reset.
  input wire logic CLK_SYS,
  input wire logic RST_B,
  // Write side pins.
  input wire logic WRITE_CLOCK,
  input wire logic [NUM_Q-1:0] QUEUE_WRITE_ENABLE,
  input wire logic [DATA_W-1:0] WRITE_DATA,
  output logic WRITE_READY,
  // Read side pins.
  input wire logic READ_CLOCK,
  input wire logic OUTPUT_READ_ENABLE,
  input wire logic READ_QUEUE_SELECT_LSB,
  input wire logic READ_QUEUE_SELECT_MSB,
  output logic [DATA_W-1:0] READ_DATA,
  output logic READ_VALID,
  output logic READ_CELL_START,
  // Level flags, low while a queue is above its set threshold.
  output logic QUEUE1_LEVEL_FLAG,
  output logic QUEUE2_LEVEL_FLAG,
  output logic QUEUE3_LEVEL_FLAG,
  // Auxiliary configuration bus.
  input wire logic [REG_AW-1:0] AUX_ADDR,
  input wire logic [REG_DW-1:0] AUX_WDATA,
  input wire logic AUX_WRITE,
  output logic [REG_DW-1:0] AUX_RDATA
);

  localparam int ENTRY_W = QID_W + DATA_W;

  // Pin synchronisers.
  logic wclk_m, wclk_s, wclk_d;
  logic [NUM_Q-1:0] wen_m, wen_s;
  logic [DATA_W-1:0] wdat_m, wdat_s;
  logic rclk_m, rclk_s, rclk_d;
  logic ren_m, ren_s;
  logic [1:0] sel_m, sel_s;
  logic awr_m, awr_s, awr_d;
  logic [REG_AW-1:0] aadr_m, aadr_s;
  logic [REG_DW-1:0] adat_m, adat_s;

  // Configuration registers.
  logic [PORT_W-1:0] port_fmt;
  logic [LEN1_W-1:0] q1_len;
  logic [LEN_W-1:0] q2_len;
  logic [LEN_W-1:0] q3_len;
  logic [CSZ_W-1:0] cell_words;
  logic [REG_DW-1:0] lvl_set [NUM_Q];
  logic [REG_DW-1:0] lvl_clr [NUM_Q];

  // Queue state.
  logic [MEM_AW-1:0] wofs [NUM_Q];
  logic [MEM_AW-1:0] rofs [NUM_Q];
  logic [QSZ_W-1:0] words [NUM_Q];
  logic [CSZ_W-1:0] wpos [NUM_Q];
  logic [CSZ_W-1:0] rpos [NUM_Q];
  logic [CELL_CNT_W-1:0] cells [NUM_Q];
  logic [NUM_Q-1:0] lvl_flag;
  logic [QSZ_W-1:0] qsz [NUM_Q];
  logic [QSZ_W-1:0] qbase [NUM_Q];
  logic [NUM_Q-1:0] wr_hit, rd_hit, wend, rend;

  logic [DATA_W-1:0] mem [MEM_WORDS];

  logic wr_edge, rd_edge, aux_wr;
  logic fifo_push, fifo_in_ready, fifo_out_valid, drain_ready;
  logic [QID_W-1:0] push_qid, wr_q, rd_q;
  logic [ENTRY_W-1:0] fifo_in, fifo_out;
  logic wr_fire, rd_fire;
  logic [MEM_AW-1:0] waddr, raddr;
  logic [DATA_W-1:0] mem_rdata;
  logic [REG_DW-1:0] next_aux_rdata;

  // Write pins cross by two flops; the third flop only finds the edge.
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      wclk_m <= 1'b0;
      wclk_s <= 1'b0;
      wclk_d <= 1'b0;
      wen_m <= '0;
      wen_s <= '0;
      wdat_m <= '0;
      wdat_s <= '0;
    end else begin
      wclk_m <= WRITE_CLOCK;
      wclk_s <= wclk_m;
      wclk_d <= wclk_s;
      wen_m <= QUEUE_WRITE_ENABLE;
      wen_s <= wen_m;
      wdat_m <= WRITE_DATA;
      wdat_s <= wdat_m;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      rclk_m <= 1'b0;
      rclk_s <= 1'b0;
      rclk_d <= 1'b0;
      ren_m <= 1'b0;
      ren_s <= 1'b0;
      sel_m <= '0;
      sel_s <= '0;
    end else begin
      rclk_m <= READ_CLOCK;
      rclk_s <= rclk_m;
      rclk_d <= rclk_s;
      ren_m <= OUTPUT_READ_ENABLE;
      ren_s <= ren_m;
      sel_m <= {READ_QUEUE_SELECT_MSB, READ_QUEUE_SELECT_LSB};
      sel_s <= sel_m;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      awr_m <= 1'b0;
      awr_s <= 1'b0;
      awr_d <= 1'b0;
      aadr_m <= '0;
      aadr_s <= '0;
      adat_m <= '0;
      adat_s <= '0;
    end else begin
      awr_m <= AUX_WRITE;
      awr_s <= awr_m;
      awr_d <= awr_s;
      aadr_m <= AUX_ADDR;
      aadr_s <= aadr_m;
      adat_m <= AUX_WDATA;
      adat_s <= adat_m;
    end
  end

  assign wr_edge = wclk_s && !wclk_d;
  assign rd_edge = rclk_s && !rclk_d;
  assign aux_wr = awr_s && !awr_d;

  // A register write lands on the rising edge of the write strobe.
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      port_fmt <= PORT_RST;
      q1_len <= Q1_LEN_RST;
      q2_len <= Q2_LEN_RST;
      q3_len <= Q3_LEN_RST;
      cell_words <= CSZ_RST;
      for (int q = 0; q < NUM_Q; q++) begin
        lvl_set[q] <= LVL_SET_RST[q];
        lvl_clr[q] <= LVL_CLR_RST[q];
      end
    end else if (aux_wr) begin
      case (aadr_s)
        REG_PORT: port_fmt <= adat_s[PORT_W-1:0];
        REG_Q1_LEN: q1_len <= adat_s[LEN1_W-1:0];
        REG_Q2_LEN: q2_len <= adat_s[LEN_W-1:0];
        REG_Q3_LEN: q3_len <= adat_s[LEN_W-1:0];
        REG_CELL_SIZE: cell_words <= adat_s[CSZ_W-1:0];
        REG_L1_SET: lvl_set[0] <= adat_s;
        REG_L1_CLR: lvl_clr[0] <= adat_s;
        REG_L2_SET: lvl_set[1] <= adat_s;
        REG_L2_CLR: lvl_clr[1] <= adat_s;
        REG_L3_SET: lvl_set[2] <= adat_s;
        REG_L3_CLR: lvl_clr[2] <= adat_s;
        default: begin
        end
      endcase
    end
  end

  // Unmapped indices read as zero.
  always_comb begin
    next_aux_rdata = '0;
    case (aadr_s)
      REG_PORT: next_aux_rdata = {4'h0, port_fmt};
      REG_Q1_LEN: next_aux_rdata = {4'h0, q1_len};
      REG_Q2_LEN: next_aux_rdata = {5'h00, q2_len};
      REG_Q3_LEN: next_aux_rdata = {5'h00, q3_len};
      REG_CELL_SIZE: next_aux_rdata = {3'h0, cell_words};
      REG_L1_SET: next_aux_rdata = lvl_set[0];
      REG_L1_CLR: next_aux_rdata = lvl_clr[0];
      REG_L2_SET: next_aux_rdata = lvl_set[1];
      REG_L2_CLR: next_aux_rdata = lvl_clr[1];
      REG_L3_SET: next_aux_rdata = lvl_set[2];
      REG_L3_CLR: next_aux_rdata = lvl_clr[2];
      default: next_aux_rdata = '0;
    endcase
  end

  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      AUX_RDATA <= '0;
    end else begin
      AUX_RDATA <= next_aux_rdata;
    end
  end

  // Only the lowest asserted enable is honoured.
  always_comb begin
    push_qid = 2'h0;
    if (wen_s[0]) begin
      push_qid = 2'h0;
    end else if (wen_s[1]) begin
      push_qid = 2'h1;
    end else if (wen_s[2]) begin
      push_qid = 2'h2;
    end
  end

  assign fifo_push = wr_edge && (|wen_s);
  assign fifo_in = {push_qid, wdat_s};

  mqc_fifo #(
    .WIDTH(ENTRY_W),
    .DEPTH(BUF_DEPTH)
  ) u_in_fifo (
    .clk(CLK_SYS),
    .rst_b(RST_B),
    .in_valid(fifo_push),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in),
    .out_valid(fifo_out_valid),
    .out_ready(drain_ready),
    .out_data(fifo_out)
  );

  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      WRITE_READY <= 1'b0;
    end else begin
      WRITE_READY <= fifo_in_ready;
    end
  end

  // Queues sit back to back in block steps of 256 words.
  always_comb begin
    qsz[0] = {q1_len, 8'h00};
    qsz[1] = {1'b0, q2_len, 8'h00};
    qsz[2] = {1'b0, q3_len, 8'h00};
    qbase[0] = '0;
    qbase[1] = qsz[0];
    qbase[2] = qsz[0] + qsz[1];
  end

  // Words for a queue of length zero are dropped so they never stall the buffer.
  assign wr_q = fifo_out[ENTRY_W-1:DATA_W];
  assign drain_ready = (qsz[wr_q] == '0) || (words[wr_q] < qsz[wr_q]);
  assign wr_fire = fifo_out_valid && drain_ready && (qsz[wr_q] != '0);
  assign waddr = MEM_AW'(qbase[wr_q] + {1'b0, wofs[wr_q]});

  // A read needs one complete cell in the chosen queue.
  assign rd_q = mqc_sel_queue(sel_s);
  assign rd_fire = rd_edge && ren_s && (cells[rd_q] != '0);
  assign raddr = MEM_AW'(qbase[rd_q] + {1'b0, rofs[rd_q]});
  assign mem_rdata = mem[raddr];

  always_ff @(posedge CLK_SYS) begin
    if (wr_fire) begin
      mem[waddr] <= fifo_out[DATA_W-1:0];
    end
  end

  always_comb begin
    for (int q = 0; q < NUM_Q; q++) begin
      wr_hit[q] = wr_fire && (wr_q == QID_W'(q));
      rd_hit[q] = rd_fire && (rd_q == QID_W'(q));
      wend[q] = wr_hit[q] && (wpos[q] == cell_words - 6'h01);
      rend[q] = rd_hit[q] && (rpos[q] == cell_words - 6'h01);
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      for (int q = 0; q < NUM_Q; q++) begin
        wofs[q] <= '0;
        rofs[q] <= '0;
        words[q] <= '0;
        wpos[q] <= '0;
        rpos[q] <= '0;
        cells[q] <= '0;
      end
    end else begin
      for (int q = 0; q < NUM_Q; q++) begin
        if (wr_hit[q]) begin
          wofs[q] <= ({1'b0, wofs[q]} == qsz[q] - 13'h0001) ? '0 :
                     wofs[q] + 12'h001;
          wpos[q] <= wend[q] ? '0 : wpos[q] + 6'h01;
        end
        if (rd_hit[q]) begin
          rofs[q] <= ({1'b0, rofs[q]} == qsz[q] - 13'h0001) ? '0 :
                     rofs[q] + 12'h001;
          rpos[q] <= rend[q] ? '0 : rpos[q] + 6'h01;
        end
        words[q] <= words[q] + {12'h000, wr_hit[q]} -
                    {12'h000, rd_hit[q]};
        cells[q] <= cells[q] + {9'h000, wend[q]} - {9'h000, rend[q]};
      end
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      READ_DATA <= '0;
      READ_VALID <= 1'b0;
      READ_CELL_START <= 1'b0;
    end else begin
      READ_VALID <= rd_fire;
      READ_CELL_START <= rd_fire && (rpos[rd_q] == '0);
      if (rd_fire) begin
        READ_DATA <= mem_rdata;
      end
    end
  end

  // The set threshold takes priority over the clear threshold.
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      lvl_flag <= '1;
    end else begin
      for (int q = 0; q < NUM_Q; q++) begin
        if (cells[q] >= {1'b0, lvl_set[q]}) begin
          lvl_flag[q] <= 1'b0;
        end else if (cells[q] <= {1'b0, lvl_clr[q]}) begin
          lvl_flag[q] <= 1'b1;
        end
      end
    end
  end

  assign QUEUE1_LEVEL_FLAG = lvl_flag[0];
  assign QUEUE2_LEVEL_FLAG = lvl_flag[1];
  assign QUEUE3_LEVEL_FLAG = lvl_flag[2];

  a_write_store: assert property (
    @(posedge CLK_SYS) disable iff (!RST_B)
    wr_hit[0] && !rd_hit[0] |=> words[0] == $past(words[0]) + 13'h0001)
    else $error("queue one word count did not grow on a write");

  a_read_deliver: assert property (
    @(posedge CLK_SYS) disable iff (!RST_B)
    rd_fire |=> READ_VALID && READ_DATA == $past(mem_rdata))
    else $error("read did not deliver the addressed word");

  a_read_idle: assert property (
    @(posedge CLK_SYS) disable iff (!RST_B)
    !rd_fire |=> !READ_VALID)
    else $error("read valid without a read");

  a_write_idle: assert property (
    @(posedge CLK_SYS) disable iff (!RST_B)
    !(wr_edge && (wen_s != '0))
    |=> u_in_fifo.count <= $past(u_in_fifo.count))
    else $error("word captured without an enabled write edge");

  a_select_two: assert property (
    @(posedge CLK_SYS) disable iff (!RST_B)
    rd_fire && sel_s == 2'h2 && !wr_hit[1]
    |=> words[1] == $past(words[1]) - 13'h0001)
    else $error("select 10 did not read queue two");

  a_cell_count: assert property (
    @(posedge CLK_SYS) disable iff (!RST_B)
    wend[0] && !rend[0] |=> cells[0] == $past(cells[0]) + 10'h001)
    else $error("completed cell not counted");

  a_cfg_write: assert property (
    @(posedge CLK_SYS) disable iff (!RST_B)
    aux_wr && aadr_s == REG_CELL_SIZE
    |=> cell_words == CSZ_W'($past(adat_s)))
    else $error("cell size register write lost");

  a_flag1_set: assert property (
    @(posedge CLK_SYS) disable iff (!RST_B)
    cells[0] >= {1'b0, lvl_set[0]} |=> !QUEUE1_LEVEL_FLAG)
    else $error("flag one not low at set threshold");

  a_flag1_clear: assert property (
    @(posedge CLK_SYS) disable iff (!RST_B)
    cells[0] < {1'b0, lvl_set[0]} && cells[0] <= {1'b0, lvl_clr[0]}
    |=> QUEUE1_LEVEL_FLAG)
    else $error("flag one not high at clear threshold");

  a_flag2_set: assert property (
    @(posedge CLK_SYS) disable iff (!RST_B)
    cells[1] >= {1'b0, lvl_set[1]} |=> !QUEUE2_LEVEL_FLAG)
    else $error("flag two not low at set threshold");

  a_flag3_hold: assert property (
    @(posedge CLK_SYS) disable iff (!RST_B)
    cells[2] < {1'b0, lvl_set[2]} && cells[2] > {1'b0, lvl_clr[2]}
    |=> QUEUE3_LEVEL_FLAG == $past(QUEUE3_LEVEL_FLAG))
    else $error("flag three moved inside its hysteresis band");

endmodule // mqc_core

// *** mqc_cell_source.sv ***
module mqc_cell_source
  import mqc_pkg::*;
(
  // Clock.
  input wire logic clk,
  // Write side pins.
  output logic wr_clock,
  output logic [NUM_Q-1:0] wr_enable,
  output logic [DATA_W-1:0] wr_data
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    wr_clock = 1'b0;
    wr_enable = '0;
    wr_data = '0;
  end

  // Sends n words to queue q, one per write clock period of seven cycles.
  task automatic send_words(input int q, input int n,
                            input logic [DATA_W-1:0] base);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      #1;
      wr_enable = '0;
      wr_enable[q] = 1'b1;
      wr_data = base + DATA_W'(i);
      repeat (3) @(posedge clk);
      #1;
      wr_clock = 1'b1;
      repeat (3) @(posedge clk);
      #1;
      wr_clock = 1'b0;
    end
    @(posedge clk);
    #1;
    wr_enable = '0;
    // Released data shows garbage rather than a stale word.
    wr_data = ~wr_data;
  endtask
endmodule // mqc_cell_source

// *** mqc_core_test.sv ***
module mqc_core_test;
  timeunit 1ns;
  timeprecision 100ps;
  import mqc_pkg::*;

  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic wr_clock;
  logic [NUM_Q-1:0] wr_enable;
  logic [DATA_W-1:0] wr_data;
  logic rd_clock = 1'b0;
  logic rd_enable = 1'b0;
  logic rd_sel_lsb = 1'b0;
  logic rd_sel_msb = 1'b0;
  logic [REG_AW-1:0] aux_addr = '0;
  logic [REG_DW-1:0] aux_wdata = '0;
  logic aux_write = 1'b0;
  logic [DATA_W-1:0] read_data;
  logic [REG_DW-1:0] aux_rdata;
  logic read_valid, read_cell_start, write_ready;
  logic flag1, flag2, flag3;
  int n_errors = 0;
  int checks = 0;

  always #5 clk_sys = ~clk_sys;

  mqc_cell_source i_mqc_cell_source (
    .clk(clk_sys),
    .wr_clock(wr_clock),
    .wr_enable(wr_enable),
    .wr_data(wr_data)
  );

  mqc_core i_mqc_core (
    .CLK_SYS(clk_sys),
    .RST_B(rst_b),
    .WRITE_CLOCK(wr_clock),
    .QUEUE_WRITE_ENABLE(wr_enable),
    .WRITE_DATA(wr_data),
    .WRITE_READY(write_ready),
    .READ_CLOCK(rd_clock),
    .OUTPUT_READ_ENABLE(rd_enable),
    .READ_QUEUE_SELECT_LSB(rd_sel_lsb),
    .READ_QUEUE_SELECT_MSB(rd_sel_msb),
    .READ_DATA(read_data),
    .READ_VALID(read_valid),
    .READ_CELL_START(read_cell_start),
    .QUEUE1_LEVEL_FLAG(flag1),
    .QUEUE2_LEVEL_FLAG(flag2),
    .QUEUE3_LEVEL_FLAG(flag3),
    .AUX_ADDR(aux_addr),
    .AUX_WDATA(aux_wdata),
    .AUX_WRITE(aux_write),
    .AUX_RDATA(aux_rdata)
  );

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic check_val(input string what, input logic [DATA_W-1:0] exp,
                           input logic [DATA_W-1:0] got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check_bit(input string what, input logic exp,
                           input logic got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic reg_write(input logic [REG_AW-1:0] a,
                           input logic [REG_DW-1:0] d);
    @(posedge clk_sys);
    #1;
    aux_addr = a;
    aux_wdata = d;
    repeat (3) @(posedge clk_sys);
    #1;
    aux_write = 1'b1;
    repeat (4) @(posedge clk_sys);
    #1;
    aux_write = 1'b0;
    repeat (3) @(posedge clk_sys);
  endtask

  task automatic reg_check(input logic [REG_AW-1:0] a,
                           input logic [REG_DW-1:0] e);
    @(posedge clk_sys);
    #1;
    aux_addr = a;
    repeat (4) @(posedge clk_sys);
    #1;
    check_val("aux_rdata", DATA_W'(e), DATA_W'(aux_rdata));
  endtask

  // One read clock period; catches the single-cycle valid pulse.
  task automatic read_word(input logic [1:0] sel, input logic en,
                           output logic got, output logic [DATA_W-1:0] d,
                           output logic sc);
    @(posedge clk_sys);
    #1;
    {rd_sel_msb, rd_sel_lsb} = sel;
    rd_enable = en;
    got = 1'b0;
    sc = 1'b0;
    d = '0;
    repeat (3) @(posedge clk_sys);
    #1;
    rd_clock = 1'b1;
    repeat (6) begin
      @(posedge clk_sys);
      #1;
      if (read_valid === 1'b1) begin
        got = 1'b1;
        d = read_data;
        sc = read_cell_start;
      end
    end
    rd_clock = 1'b0;
    repeat (3) @(posedge clk_sys);
  endtask

  task automatic expect_cell(input logic [1:0] sel,
                             input logic [DATA_W-1:0] base, input int n);
    logic got, sc;
    logic [DATA_W-1:0] d;
    for (int i = 0; i < n; i++) begin
      read_word(sel, 1'b1, got, d, sc);
      check_bit("read_valid", 1'b1, got);
      check_val("read_data", base + DATA_W'(i), d);
      check_bit("read_cell_start", i == 0, sc);
    end
  endtask

  task automatic expect_none(input logic [1:0] sel, input logic en);
    logic got, sc;
    logic [DATA_W-1:0] d;
    read_word(sel, en, got, d, sc);
    check_bit("read_valid", 1'b0, got);
  endtask

  task automatic send(input int q, input int n, input logic [DATA_W-1:0] b);
    i_mqc_cell_source.send_words(q, n, b);
    repeat (10) @(posedge clk_sys);
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys);
    n_errors++;
    $display("BAD watchdog expected done seen hang");
    finish_test();
  end

  initial begin
    logic [REG_DW-1:0] rst_exp [12];
    rst_exp = '{9'h000, 9'h008, 9'h006, 9'h002, 9'h01B, 9'h047, 9'h046,
                9'h033, 9'h032, 9'h00D, 9'h00C, 9'h000};
    repeat (4) @(posedge clk_sys);
    #1;
    rst_b = 1'b1;
    repeat (2) @(posedge clk_sys);

    for (int i = 0; i < 12; i++) begin
      reg_check(REG_AW'(i), rst_exp[i]);
    end
    check_bit("flag1", 1'b1, flag1);
    check_bit("write_ready", 1'b1, write_ready);
    $display("test reset_values done");

    reg_write(REG_CELL_SIZE, 9'h00A);
    reg_write(REG_L1_SET, 9'h002);
    reg_write(REG_L1_CLR, 9'h001);
    reg_write(REG_L3_SET, 9'h17F);
    reg_write(REG_L2_SET, 9'h001);
    reg_write(REG_L3_CLR, 9'h000);
    reg_write(4'hB, 9'h1FF);
    reg_check(REG_CELL_SIZE, 9'h00A);
    reg_check(REG_L1_SET, 9'h002);
    reg_check(REG_L1_CLR, 9'h001);
    reg_check(REG_L3_SET, 9'h17F);
    reg_check(4'hB, 9'h000);
    $display("test register_write done");

    send(0, 10, 18'h01000);
    check_bit("flag1", 1'b1, flag1);
    send(0, 10, 18'h02000);
    check_bit("flag1", 1'b0, flag1);
    expect_none(2'h0, 1'b0);
    expect_cell(2'h0, 18'h01000, 10);
    repeat (6) @(posedge clk_sys);
    check_bit("flag1", 1'b1, flag1);
    expect_cell(2'h1, 18'h02000, 10);
    expect_none(2'h0, 1'b1);
    $display("test queue_one done");

    send(2, 5, 18'h03000);
    expect_none(2'h3, 1'b1);
    send(1, 10, 18'h04000);
    check_bit("flag2", 1'b0, flag2);
    send(2, 5, 18'h03005);
    expect_cell(2'h3, 18'h03000, 10);
    expect_cell(2'h2, 18'h04000, 10);
    expect_none(2'h2, 1'b1);
    check_bit("flag2", 1'b1, flag2);
    check_bit("flag3", 1'b1, flag3);
    $display("test queues_two_three done");

    finish_test();
  end
endmodule // mqc_core_test
